//--- logic/gdms_pkg.sv
/*
  Constants shared by the drive-mode block: register addresses, reset values,
  port geometry and the four pin drive-mode codes.
  Assumes an 8-bit register bus where registers sit at their printed offsets.
*/
`default_nettype none

package gdms_pkg;

  localparam int NUM_PORTS = 4;
  localparam int PORT_PINS = 8;
  localparam int ALL_PINS = NUM_PORTS * PORT_PINS;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // Pins actually bonded per port; the last port has only four.
  localparam int PORT_PIN_COUNT [NUM_PORTS] = '{8, 8, 8, 4};
  localparam logic [DATA_W-1:0] PORT_PIN_MASK [NUM_PORTS] = '{8'hFF, 8'hFF, 8'hFF, 8'h0F};

  // Most significant mode bit registers, one per port.
  localparam logic [ADDR_W-1:0] ADDR_MODE_HIGH [NUM_PORTS] = '{8'h01, 8'h05, 8'h09, 8'h0D};
  // Least significant mode bit registers, one per port.
  localparam logic [ADDR_W-1:0] ADDR_MODE_LOW [NUM_PORTS] = '{8'h00, 8'h04, 8'h08, 8'h0C};

  localparam logic [DATA_W-1:0] MODE_HIGH_RST = 8'hFF;
  localparam logic [DATA_W-1:0] MODE_LOW_RST = 8'h00;
  localparam logic [DATA_W-1:0] RDATA_IDLE = 8'h00;
  localparam logic [DATA_W-1:0] RDATA_UNMAPPED = 8'h00;
  localparam logic [DATA_W-1:0] BUS_RST = 8'h00;

  // Pin drive mode, written as {high bit, low bit}.
  localparam logic [1:0] MODE_PULLUP = 2'h0;
  localparam logic [1:0] MODE_STRONG = 2'h1;
  localparam logic [1:0] MODE_HIZ = 2'h2;
  localparam logic [1:0] MODE_OPEN_DRAIN_LOW = 2'h3;

endpackage

`default_nettype wire

//--- logic/gdms_mode_bank.sv
/*
  One port's pair of drive-mode registers: low mode bits and high mode bits.
  Assumes write strobes are already decoded for this port and last one cycle.
*/
`default_nettype none

module gdms_mode_bank
  import gdms_pkg::*;
#(
  parameter int PINS = PORT_PINS
) (
  input wire logic i_clk,                   // System clock.
  input wire logic i_arst_n,                // Asynchronous reset, active low.
  input wire logic i_ce,                    // Clock enable; low freezes state.
  input wire logic i_wr_low,                // Write strobe, low mode bit register.
  input wire logic i_wr_high,               // Write strobe, high mode bit register.
  input wire logic [DATA_W-1:0] i_wdata,    // Write data.
  output logic [DATA_W-1:0] o_low_bits,     // Low mode bit of each pin.
  output logic [DATA_W-1:0] o_high_bits     // High mode bit of each pin.
);

  // Each register byte holds one mode bit for each pin of the port.
  for (genvar b = 0; b < PORT_PINS; b++) begin : g_bit
    if (b < PINS) begin : g_live
      logic low_ff;
      logic high_ff;

      always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          low_ff <= MODE_LOW_RST[b];
        end else if (i_ce && i_wr_low) begin
          low_ff <= i_wdata[b];
        end
      end

      always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          high_ff <= MODE_HIGH_RST[b];
        end else if (i_ce && i_wr_high) begin
          high_ff <= i_wdata[b];
        end
      end

      assign o_low_bits[b] = low_ff;
      assign o_high_bits[b] = high_ff;
    end else begin : g_absent
      // Unbonded pins stay in the reset mode for good.
      assign o_low_bits[b] = MODE_LOW_RST[b];
      assign o_high_bits[b] = MODE_HIGH_RST[b];
    end
  end

endmodule

`default_nettype wire

//--- logic/gdms_pin_drive.sv
/*
  Output stage of one pin: turns the two-bit drive mode and the level to drive
  into registered driver controls, and samples the pin when its input is on.
  Assumes the pin input is synchronous to the system clock.
*/
`default_nettype none

module gdms_pin_drive
  import gdms_pkg::*;
(
  input wire logic i_clk,          // System clock.
  input wire logic i_arst_n,       // Asynchronous reset, active low.
  input wire logic i_ce,           // Clock enable; low freezes state.
  input wire logic [1:0] i_mode,   // Drive mode {high bit, low bit}.
  input wire logic i_level,        // Level the port wants on the pin.
  input wire logic i_pin_in,       // Level seen on the pin.
  output logic o_out,              // Strong driver value.
  output logic o_oe,               // Strong driver enable, high while driving.
  output logic o_pullup,           // Resistive pull-up enable.
  output logic o_ibuf_en,          // Digital input buffer enable.
  output logic o_din               // Sampled pin input, zero while disabled.
);

  logic nxt_out;
  logic nxt_oe;
  logic nxt_pullup;
  logic nxt_ibuf_en;

  always_comb begin
    nxt_out = 1'b0;
    nxt_oe = 1'b0;
    nxt_pullup = 1'b0;
    nxt_ibuf_en = 1'b1;
    case (i_mode)
      MODE_PULLUP: begin
        nxt_out = 1'b0;
        nxt_oe = ~i_level;
        nxt_pullup = i_level;
      end
      MODE_STRONG: begin
        nxt_out = i_level;
        nxt_oe = 1'b1;
      end
      MODE_HIZ: begin
        nxt_ibuf_en = 1'b0;
      end
      MODE_OPEN_DRAIN_LOW: begin
        nxt_out = 1'b0;
        nxt_oe = ~i_level;
      end
      default: begin
        nxt_ibuf_en = 1'b0;
      end
    endcase
  end

  // Driver controls follow mode and level every enabled cycle.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_out <= 1'b0;
      o_oe <= 1'b0;
      o_pullup <= 1'b0;
      o_ibuf_en <= 1'b0;
    end else if (i_ce) begin
      o_out <= nxt_out;
      o_oe <= nxt_oe;
      o_pullup <= nxt_pullup;
      o_ibuf_en <= nxt_ibuf_en;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_din <= 1'b0;
    end else if (i_ce) begin
      o_din <= nxt_ibuf_en & i_pin_in;
    end
  end

endmodule

`default_nettype wire

//--- logic/gdms_top.sv
/*
  Drive-mode selection for four general purpose ports: the mode registers,
  their register-bus slave and one output stage per pin.
  Assumes a one-cycle write/read strobe bus with read data one cycle later,
  and pin drivers outside that obey out, enable and pull-up controls.
*/
//
// Behaviour
// - Each pin's output behaviour comes from a two-bit mode split over two registers.
// - Pin n uses bit n of both mode registers of its port.
// - First register gives the low mode bit, second register the high mode bit.
// - Each mode register holds one bit for each pin of its port: eight pins, four on port 3.
// - Mode 00: resistive high, strong low; mode 01: strong both levels.
// - Mode 10 floats the pin, disables input; high register resets to all ones.
// - Mode 11 drives low strongly, floats high; inputs should set data high.
// - Upper nibble of four-pin port registers reads the last data bus value.
// - High mode registers sit at 01h, 05h, 09h, 0Dh, readable and writable.
`default_nettype none

module gdms_top
  import gdms_pkg::*;
(
  input wire logic I_SYS_CLK,                  // System clock, 200 MHz.
  input wire logic I_ARST_N,                   // Asynchronous reset, active low.
  input wire logic I_CE,                       // Clock enable; low freezes state.
  input wire logic [ADDR_W-1:0] I_ADDR,        // Register address.
  input wire logic [DATA_W-1:0] I_WDATA,       // Register write data.
  input wire logic I_WR,                       // Write strobe.
  input wire logic I_RD,                       // Read strobe.
  input wire logic [ALL_PINS-1:0] I_PORT_LEVEL, // Port data bits, pin p*8+n.
  input wire logic [ALL_PINS-1:0] I_PIN_IN,    // Pin levels, pin p*8+n.
  output logic [DATA_W-1:0] O_RDATA,           // Read data, cycle after read.
  output logic [ALL_PINS-1:0] O_PIN_OUT,       // Strong driver value per pin.
  output logic [ALL_PINS-1:0] O_PIN_OE,        // Strong driver enable per pin.
  output logic [ALL_PINS-1:0] O_PIN_PULLUP,    // Resistive pull-up per pin.
  output logic [ALL_PINS-1:0] O_PIN_IBUF_EN,   // Input buffer enable per pin.
  output logic [ALL_PINS-1:0] O_PIN_DIN        // Sampled pin input per pin.
);

  logic [DATA_W-1:0] port_mode_low_bits [NUM_PORTS];
  logic [DATA_W-1:0] port_mode_high_bits [NUM_PORTS];
  logic [NUM_PORTS-1:0] wr_low;
  logic [NUM_PORTS-1:0] wr_high;
  logic [DATA_W-1:0] rd_value;
  logic [DATA_W-1:0] last_bus_ff;

  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    assign wr_low[p] = I_WR && (I_ADDR == ADDR_MODE_LOW[p]);
    assign wr_high[p] = I_WR && (I_ADDR == ADDR_MODE_HIGH[p]);

    gdms_mode_bank #(
      .PINS(PORT_PIN_COUNT[p])
    ) u_bank (
      .i_clk(I_SYS_CLK),
      .i_arst_n(I_ARST_N),
      .i_ce(I_CE),
      .i_wr_low(wr_low[p]),
      .i_wr_high(wr_high[p]),
      .i_wdata(I_WDATA),
      .o_low_bits(port_mode_low_bits[p]),
      .o_high_bits(port_mode_high_bits[p])
    );

    for (genvar n = 0; n < PORT_PINS; n++) begin : g_pin
      logic [1:0] pin_mode_pair;

      // Same bit position in both registers, high register as the upper bit.
      assign pin_mode_pair = {port_mode_high_bits[p][n], port_mode_low_bits[p][n]};

      gdms_pin_drive u_drive (
        .i_clk(I_SYS_CLK),
        .i_arst_n(I_ARST_N),
        .i_ce(I_CE),
        .i_mode(pin_mode_pair),
        .i_level(I_PORT_LEVEL[p*PORT_PINS+n]),
        .i_pin_in(I_PIN_IN[p*PORT_PINS+n]),
        .o_out(O_PIN_OUT[p*PORT_PINS+n]),
        .o_oe(O_PIN_OE[p*PORT_PINS+n]),
        .o_pullup(O_PIN_PULLUP[p*PORT_PINS+n]),
        .o_ibuf_en(O_PIN_IBUF_EN[p*PORT_PINS+n]),
        .o_din(O_PIN_DIN[p*PORT_PINS+n])
      );
    end
  end

  // Bits above a short port's pins show the last value on the data bus.
  always_comb begin
    rd_value = RDATA_UNMAPPED;
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (I_ADDR == ADDR_MODE_LOW[p]) begin
        rd_value = (port_mode_low_bits[p] & PORT_PIN_MASK[p])
                 | (last_bus_ff & ~PORT_PIN_MASK[p]);
      end else if (I_ADDR == ADDR_MODE_HIGH[p]) begin
        rd_value = (port_mode_high_bits[p] & PORT_PIN_MASK[p])
                 | (last_bus_ff & ~PORT_PIN_MASK[p]);
      end
    end
  end

  // Tracks write data, and read data on reads with no write in the same cycle.
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      last_bus_ff <= BUS_RST;
    end else if (I_CE) begin
      if (I_WR) begin
        last_bus_ff <= I_WDATA;
      end else if (I_RD) begin
        last_bus_ff <= rd_value;
      end
    end
  end

  // Read data stands for one enabled cycle after the read strobe; low I_CE holds it longer.
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_RDATA <= RDATA_IDLE;
    end else if (I_CE) begin
      O_RDATA <= I_RD ? rd_value : RDATA_IDLE;
    end
  end

endmodule

`default_nettype wire

//--- verification/gdms_monitor.sv
/*
  Assertions on the drive-mode block, seen only at its top ports.
  Assumes it is bound to gdms_top and shares its single clock.
*/
`default_nettype none

module gdms_monitor
  import gdms_pkg::*;
(
  input wire logic I_SYS_CLK, // Clock.
  input wire logic I_ARST_N, // Reset.
  input wire logic I_CE, // Enable.
  input wire logic I_RD, // Read.
  input wire logic [ALL_PINS-1:0] I_PORT_LEVEL, // Level.
  input wire logic [DATA_W-1:0] O_RDATA, // Data.
  input wire logic [ALL_PINS-1:0] O_PIN_OUT, // Out.
  input wire logic [ALL_PINS-1:0] O_PIN_OE, // Enable.
  input wire logic [ALL_PINS-1:0] O_PIN_PULLUP, // Pull-up.
  input wire logic [ALL_PINS-1:0] O_PIN_IBUF_EN // Input on.
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_ARST_N);

  sequence s_hiz;
    O_PIN_OE == '0 && O_PIN_PULLUP == '0 && O_PIN_IBUF_EN == '0;
  endsequence

  AST_RST_HIZ: assert property ($rose(I_ARST_N) |-> s_hiz ##1 s_hiz)
    else $error("pins not idle after reset");
  AST_RD_IDLE: assert property (I_CE && !I_RD |=> O_RDATA == 8'h00)
    else $error("read data without a read");
  AST_PULL_SRC: assert property (I_CE |=> (O_PIN_PULLUP & ~$past(I_PORT_LEVEL)) == '0)
    else $error("pull-up on a low level");
  AST_HIGH_SRC: assert property (I_CE |=> (O_PIN_OE & O_PIN_OUT & ~$past(I_PORT_LEVEL)) == '0)
    else $error("strong high on a low level");
  AST_OUT_GATED: assert property ((O_PIN_OUT & ~O_PIN_OE) == '0)
    else $error("out high while not driving");
  AST_ONE_SRC: assert property ((O_PIN_OE & O_PIN_PULLUP) == '0)
    else $error("pull-up and strong driver together");
  AST_HIZ_IN: assert property ((~O_PIN_IBUF_EN & (O_PIN_OE | O_PIN_PULLUP)) == '0)
    else $error("driving with input disabled");
  AST_PORT3_NIB: assert property ((O_PIN_OE[31:28] | O_PIN_PULLUP[31:28]) == 4'h0)
    else $error("absent pin driven");
  AST_FREEZE: assert property (!I_CE |=> $stable(O_PIN_OE) && $stable(O_PIN_PULLUP))
    else $error("pins moved while disabled");
endmodule

bind gdms_top gdms_monitor u_mon (.I_SYS_CLK(I_SYS_CLK), .I_ARST_N(I_ARST_N), .I_CE(I_CE),
  .I_RD(I_RD), .I_PORT_LEVEL(I_PORT_LEVEL), .O_RDATA(O_RDATA), .O_PIN_OUT(O_PIN_OUT),
  .O_PIN_OE(O_PIN_OE), .O_PIN_PULLUP(O_PIN_PULLUP), .O_PIN_IBUF_EN(O_PIN_IBUF_EN));

`default_nettype wire

//--- verification/gdms_pin_model.sv
/*
  Package pins: strong driver wins, else pull-up, else a floating level.
  Assumes driver controls come from the block's registered outputs.
*/
`default_nettype none

module gdms_pin_model
  import gdms_pkg::*;
(
  input wire logic i_clk, // Clock.
  input wire logic [ALL_PINS-1:0] i_out, // Driver value.
  input wire logic [ALL_PINS-1:0] i_oe, // Driver on.
  input wire logic [ALL_PINS-1:0] i_pullup, // Pull-up on.
  output logic [ALL_PINS-1:0] o_pin // Pin level.
);
  timeunit 1ns;
  timeprecision 100ps;
  logic flt_ff = 1'b0;
  // An undriven pin wanders, so it toggles every cycle.
  always_ff @(posedge i_clk) flt_ff <= ~flt_ff;
  assign o_pin = (i_oe & i_out) | (~i_oe & (i_pullup | {ALL_PINS{flt_ff}}));
endmodule

`default_nettype wire

//--- verification/tb_top.sv
/*
  Register and pin tests of the drive-mode block.
  Assumes the pin model closes the loop from outputs to pin inputs.
*/
`default_nettype none

module tb_top
  import gdms_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, wr = 1'b0, rd = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, lastb = 8'h00, rdata;
  logic [31:0] lvl = 32'h0, pin_in, p_out, p_oe, p_pu, p_ib, p_din;
  logic [31:0] pat [3] = '{32'h0, 32'hFFFFFFFF, 32'h0F0F0F0F};
  logic [7:0] lo [4], hi [4];
  int error_cnt = 0, n_tests = 0;

  initial forever #2.5 clk = ~clk;

  gdms_top uut (.I_SYS_CLK(clk), .I_ARST_N(rst_n), .I_CE(ce), .I_ADDR(addr),
    .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .I_PORT_LEVEL(lvl), .I_PIN_IN(pin_in),
    .O_RDATA(rdata), .O_PIN_OUT(p_out), .O_PIN_OE(p_oe), .O_PIN_PULLUP(p_pu),
    .O_PIN_IBUF_EN(p_ib), .O_PIN_DIN(p_din));
  gdms_pin_model u_pins (.i_clk(clk), .i_out(p_out), .i_oe(p_oe), .i_pullup(p_pu),
    .o_pin(pin_in));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    if (ce) lastb = d;
  endtask

  task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(32'(rdata), 32'(e));
    lastb = e;
  endtask

  // Port 3 has four pins; its upper nibble echoes the last bus byte.
  function automatic logic [7:0] ex(input int p, input logic [7:0] v);
    return (p == 3) ? {lastb[7:4], v[3:0]} : v;
  endfunction

  task automatic rd_port(input int p);
    reg_rd(ADDR_MODE_LOW[p], ex(p, lo[p]));
    reg_rd(ADDR_MODE_HIGH[p], ex(p, hi[p]));
  endtask

  task automatic chk_pins();
    logic [31:0] oe, out, pu, ib, din;
    logic [1:0] m;
    for (int i = 0; i < 32; i++) begin
      m = (i >= 28) ? MODE_HIZ : {hi[i/8][i%8], lo[i/8][i%8]};
      ib[i] = (m != MODE_HIZ);
      oe[i] = (m == MODE_STRONG) || (!lvl[i] && m != MODE_HIZ);
      out[i] = oe[i] && lvl[i];
      pu[i] = (m == MODE_PULLUP) && lvl[i];
      // A floating pin showed the model's previous level when the stage sampled it.
      din[i] = ib[i] && (oe[i] ? out[i] : (pu[i] || !u_pins.flt_ff));
    end
    chk(p_oe, oe);
    chk(p_out, out);
    chk(p_pu, pu);
    chk(p_ib, ib);
    chk(p_din, din);
  endtask

  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    #100000;
    error_cnt++;
    report_and_stop();
  end

  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    for (int p = 0; p < 4; p++) begin
      lo[p] = 8'h00;
      hi[p] = 8'hFF;
      rd_port(p);
    end
    chk_pins();
    reg_rd(8'h02, 8'h00);
    $display("test reset values done");
    for (int p = 0; p < 4; p++) begin
      lo[p] = 8'hAA ^ 8'(p);
      hi[p] = 8'hCC;
      reg_wr(ADDR_MODE_LOW[p], lo[p]);
      reg_wr(ADDR_MODE_HIGH[p], hi[p]);
      rd_port(p);
    end
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      lvl <= pat[k];
      repeat (2) @(posedge clk);
      #1 chk_pins();
    end
    $display("test drive modes done");
    @(posedge clk);
    ce <= 1'b0;
    reg_wr(ADDR_MODE_HIGH[0], 8'h00);
    @(posedge clk);
    ce <= 1'b1;
    rd_port(0);
    $display("test clock enable done");
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    lastb = 8'h00;
    for (int p = 0; p < 4; p++) begin
      lo[p] = 8'h00;
      hi[p] = 8'hFF;
      rd_port(p);
    end
    chk_pins();
    $display("test reset in mid-run done");
    report_and_stop();
  end
endmodule

`default_nettype wire
